//--- verilog/gts_pkg.sv
// Purpose: constants for the general timer set
// Assumes: 40 MHz system clock, 32-bit Avalon-MM register window
// Notes:   register byte offsets, control fields, reset values
`default_nettype none
package gts_pkg;
  // register byte offsets
  localparam logic [5:0] OFF_T1_CTRL  = 6'h00;
  localparam logic [5:0] OFF_T1_CNT   = 6'h04;
  localparam logic [5:0] OFF_T1_PER   = 6'h08;
  localparam logic [5:0] OFF_CTRL_L_A = 6'h0c;
  localparam logic [5:0] OFF_CTRL_U_A = 6'h10;
  localparam logic [5:0] OFF_CNT_L_A  = 6'h14;
  localparam logic [5:0] OFF_CNT_U_A  = 6'h18;
  localparam logic [5:0] OFF_PER_L_A  = 6'h1c;
  localparam logic [5:0] OFF_PER_U_A  = 6'h20;
  localparam logic [5:0] OFF_CTRL_L_B = 6'h24;
  localparam logic [5:0] OFF_CTRL_U_B = 6'h28;
  localparam logic [5:0] OFF_CNT_L_B  = 6'h2c;
  localparam logic [5:0] OFF_CNT_U_B  = 6'h30;
  localparam logic [5:0] OFF_PER_L_B  = 6'h34;
  localparam logic [5:0] OFF_PER_U_B  = 6'h38;
  localparam logic [5:0] OFF_FLAGS    = 6'h3c;
  // control field positions
  localparam int BIT_RUN  = 15;
  localparam int BIT_HALT = 13;
  localparam int BIT_GATE = 6;
  localparam int BIT_PS_H = 5;
  localparam int BIT_PS_L = 4;
  localparam int BIT_JOIN = 3;
  localparam int BIT_SYNC = 2;
  localparam int BIT_CSRC = 1;
  // writable bits per control register kind
  localparam logic [15:0] MASK_T1    = 16'ha076;
  localparam logic [15:0] MASK_LOWER = 16'ha07a;
  localparam logic [15:0] MASK_UPPER = 16'ha072;
  localparam logic [15:0] CTRL_RST   = 16'h0000;
  localparam logic [15:0] PER_RST    = 16'hffff;
  // prescale terminal counts (ratio minus one)
  localparam logic [7:0] PS_DIV1   = 8'h00;
  localparam logic [7:0] PS_DIV8   = 8'h07;
  localparam logic [7:0] PS_DIV64  = 8'h3f;
  localparam logic [7:0] PS_DIV256 = 8'hff;
  // flags register bit positions
  localparam int FLG_T1 = 0;
  localparam int FLG_LA = 1;
  localparam int FLG_UA = 2;
  localparam int FLG_LB = 3;
  localparam int FLG_UB = 4;
endpackage
`default_nettype wire

//--- verilog/gts_timer_set.sv
// Purpose: standalone 16-bit timer plus two joinable 16/32-bit timer pairs
// Assumes: sys_clk_i is the instruction clock; pins pass a two-flop stage
// Notes:   one Avalon-MM slave, one wait state on reads and writes
//
// Overview of operation
// RL1: standalone timer: internal, sync or async external; no async path, external clock always synchronised
// RL2: standalone flag on count matching period
// RL3: gated mode also flags on gate fall
// RL4: bit 15 starts or stops, resets zero
// RL5: bit 13 halts timer in idle
// RL6: bit 6 gates only with internal clock
// RL7: bits 5:4 prescale 1, 8, 64, 256
// RL8: bit 2 syncs external clock, standalone only; bit 2 is unused, external edges always synchronised
// RL9: bit 1 picks external rising edge
// RL10: control write while running clears prescaler
// RL11: pair timers run alone, no async mode
// RL12: lower bit 3 joins pair to 32 bits
// RL13: joined pair uses lower controls, upper flag
// RL14: joined pair counts synchronised external clock only
// RL15: upper count is high word when joined
// RL16: upper period is high word when joined
// RL17: adc trigger from pair a only
// RL18: software sets join first, run last
// RL19: tick increments; match clears and flags
// RL20: gated mode counts while gate high
`default_nettype none
module gts_timer_set
  import gts_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  // device state
  input  wire logic        idle_i,
  // external clock and gate pins
  input  wire logic        standalone_ext_clock_pin_i,
  input  wire logic [3:0]  pair_ext_clock_pin_i,
  input  wire logic        standalone_gate_i,
  input  wire logic [3:0]  pair_gate_i,
  // events
  output logic [4:0]       irq_flag_pulse_o,
  output logic             adc_trigger_o
);
  // index 0 standalone, 1 lower a, 2 upper a, 3 lower b, 4 upper b
  logic [15:0] ctrl_reg [5];
  logic [15:0] cnt_reg  [5];
  logic [15:0] per_reg  [5];
  logic [4:0]  flag_reg;
  logic [7:0]  ps_reg   [5];
  logic [4:0]  clk_s1_reg, clk_s2_reg, clk_s3_reg;
  logic [4:0]  gate_s1_reg, gate_s2_reg, gate_s3_reg;
  logic        ack_reg;
  logic [4:0]  ctrl_wr, cnt_wr, per_wr;
  logic [4:0]  inc, match, tick;
  logic [4:0]  flag_set, gate_fall;
  logic [4:0]  clk_rise, gate_lvl;
  logic [1:0]  pair_joined;
  logic [7:0]  ps_term  [5];
  logic [15:0] wdata;
  logic        wr_now, rd_now;

  assign wdata  = avs_writedata_i[15:0];
  assign wr_now = avs_write_i && ack_reg && (&avs_byteenable_i[1:0]);
  assign rd_now = avs_read_i && !ack_reg;

  // two-flop synchronisers, third stage for edge detection
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      clk_s1_reg  <= 5'h00;
      clk_s2_reg  <= 5'h00;
      clk_s3_reg  <= 5'h00;
      gate_s1_reg <= 5'h00;
      gate_s2_reg <= 5'h00;
      gate_s3_reg <= 5'h00;
    end else begin
      clk_s1_reg  <= {pair_ext_clock_pin_i, standalone_ext_clock_pin_i};
      clk_s2_reg  <= clk_s1_reg;
      clk_s3_reg  <= clk_s2_reg;
      gate_s1_reg <= {pair_gate_i, standalone_gate_i};
      gate_s2_reg <= gate_s1_reg;
      gate_s3_reg <= gate_s2_reg;
    end
  end

  // RL12: pair join bits
  assign pair_joined[0] = ctrl_reg[1][BIT_JOIN];
  assign pair_joined[1] = ctrl_reg[3][BIT_JOIN];

  // bus write decode
  always_comb begin
    ctrl_wr = 5'h00;
    cnt_wr  = 5'h00;
    per_wr  = 5'h00;
    if (wr_now) begin
      case (avs_address_i)
        OFF_T1_CTRL:  ctrl_wr[0] = 1'b1;
        OFF_T1_CNT:   cnt_wr[0]  = 1'b1;
        OFF_T1_PER:   per_wr[0]  = 1'b1;
        OFF_CTRL_L_A: ctrl_wr[1] = 1'b1;
        OFF_CTRL_U_A: ctrl_wr[2] = 1'b1;
        OFF_CNT_L_A:  cnt_wr[1]  = 1'b1;
        OFF_CNT_U_A:  cnt_wr[2]  = 1'b1;
        OFF_PER_L_A:  per_wr[1]  = 1'b1;
        OFF_PER_U_A:  per_wr[2]  = 1'b1;
        OFF_CTRL_L_B: ctrl_wr[3] = 1'b1;
        OFF_CTRL_U_B: ctrl_wr[4] = 1'b1;
        OFF_CNT_L_B:  cnt_wr[3]  = 1'b1;
        OFF_CNT_U_B:  cnt_wr[4]  = 1'b1;
        OFF_PER_L_B:  per_wr[3]  = 1'b1;
        OFF_PER_U_B:  per_wr[4]  = 1'b1;
        default: ;
      endcase
    end
  end

  // per-timer tick generation
  always_comb begin
    logic [15:0] c;
    logic        csrc, run;
    c        = 16'h0000;
    csrc     = 1'b0;
    run      = 1'b0;
    tick     = 5'h00;
    clk_rise = 5'h00;
    gate_lvl = 5'h00;
    for (int i = 0; i < 5; i++) begin
      // RL13: upper timer of a joined pair borrows lower controls
      c = ctrl_reg[i];
      if ((i == 2 && pair_joined[0]) || (i == 4 && pair_joined[1])) begin
        c = ctrl_reg[i-1];
      end
      csrc = c[BIT_CSRC];
      // RL4: run control, RL5: halt in idle
      run = c[BIT_RUN] && !(c[BIT_HALT] && idle_i);
      // RL8: bit 2 is not decoded, the standalone timer also counts synchronised edges;
      // RL11 RL14: pair timers always use synchronised edges
      clk_rise[i] = clk_s2_reg[i] && !clk_s3_reg[i];
      gate_lvl[i] = gate_s2_reg[i];
      // RL1: internal or external count
      if (run) begin
        // RL9: clock source select
        if (csrc) begin
          tick[i] = clk_rise[i];
        // RL6 RL20: gated accumulation with internal clock
        end else if (c[BIT_GATE]) begin
          tick[i] = gate_lvl[i];
        end else begin
          tick[i] = 1'b1;
        end
      end
    end
  end

  // RL3: gate falling edge with gating enabled and internal clock
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      gate_fall[i] = ctrl_reg[i][BIT_RUN] && ctrl_reg[i][BIT_GATE]
                     && !ctrl_reg[i][BIT_CSRC]
                     && gate_s3_reg[i] && !gate_s2_reg[i];
    end
    // a joined upper timer has no gate of its own
    if (pair_joined[0]) gate_fall[2] = 1'b0;
    if (pair_joined[1]) gate_fall[4] = 1'b0;
  end

  // RL7: prescale ratio and increment strobes
  always_comb begin
    logic [1:0] sel;
    sel = 2'b00;
    for (int i = 0; i < 5; i++) begin
      sel = ctrl_reg[i][BIT_PS_H:BIT_PS_L];
      if ((i == 2 && pair_joined[0]) || (i == 4 && pair_joined[1])) begin
        sel = ctrl_reg[i-1][BIT_PS_H:BIT_PS_L];
      end
      case (sel)
        2'b00:   ps_term[i] = PS_DIV1;
        2'b01:   ps_term[i] = PS_DIV8;
        2'b10:   ps_term[i] = PS_DIV64;
        default: ps_term[i] = PS_DIV256;
      endcase
      inc[i] = tick[i] && (ps_reg[i] == ps_term[i]);
    end
  end

  // prescaler counters
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) ps_reg[i] <= 8'h00;
    end else begin
      for (int i = 0; i < 5; i++) begin
        // RL10: control write while running clears prescaler
        if (ctrl_wr[i] && ctrl_reg[i][BIT_RUN]) begin
          ps_reg[i] <= 8'h00;
        end else if (tick[i]) begin
          ps_reg[i] <= (ps_reg[i] >= ps_term[i]) ? 8'h00 : ps_reg[i] + 8'h01;
        end
      end
    end
  end

  // period match, 16-bit or 32-bit per pair
  always_comb begin
    for (int i = 0; i < 5; i++) match[i] = (cnt_reg[i] == per_reg[i]);
    // RL15 RL16: joined pair compares the full 32-bit word
    if (pair_joined[0]) begin
      match[1] = match[1] && match[2];
      match[2] = match[1];
    end
    if (pair_joined[1]) begin
      match[3] = match[3] && match[4];
      match[4] = match[3];
    end
  end

  // RL19: count registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) cnt_reg[i] <= 16'h0000;
    end else begin
      for (int i = 0; i < 5; i++) begin
        if (cnt_wr[i]) begin
          cnt_reg[i] <= wdata;
        end else if ((i == 2 && pair_joined[0]) || (i == 4 && pair_joined[1])) begin
          // RL15: high word advances on low word carry
          if (inc[i-1]) begin
            if (match[i-1]) cnt_reg[i] <= 16'h0000;
            else if (cnt_reg[i-1] == 16'hffff) cnt_reg[i] <= cnt_reg[i] + 16'h0001;
          end
        end else if (inc[i]) begin
          cnt_reg[i] <= match[i] ? 16'h0000 : cnt_reg[i] + 16'h0001;
        end
      end
    end
  end

  // flag events
  always_comb begin
    for (int i = 0; i < 5; i++) flag_set[i] = (inc[i] && match[i]) || gate_fall[i];
    // RL13: joined match reported on upper flag only
    if (pair_joined[0]) begin
      flag_set[2] = (inc[1] && match[1]) || gate_fall[1];
      flag_set[1] = 1'b0;
    end
    if (pair_joined[1]) begin
      flag_set[4] = (inc[3] && match[3]) || gate_fall[3];
      flag_set[3] = 1'b0;
    end
  end

  // RL2: sticky flags, write one clears, set wins
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      flag_reg <= 5'h00;
    end else if (wr_now && avs_address_i == OFF_FLAGS) begin
      flag_reg <= (flag_reg & ~avs_writedata_i[4:0]) | flag_set;
    end else begin
      flag_reg <= flag_reg | flag_set;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      irq_flag_pulse_o <= 5'h00;
      adc_trigger_o    <= 1'b0;
    end else begin
      irq_flag_pulse_o <= flag_set;
      // RL17: adc trigger from pair a upper event
      adc_trigger_o    <= flag_set[FLG_UA];
    end
  end

  // control and period registers
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < 5; i++) begin
        ctrl_reg[i] <= CTRL_RST;
        per_reg[i]  <= PER_RST;
      end
    end else begin
      for (int i = 0; i < 5; i++) begin
        // RL4 RL12: writable control fields
        if (ctrl_wr[i]) begin
          ctrl_reg[i] <= wdata & ((i == 0) ? MASK_T1 :
                                  (i == 1 || i == 3) ? MASK_LOWER : MASK_UPPER);
        end
        if (per_wr[i]) per_reg[i] <= wdata;
      end
    end
  end

  // avalon slave: one wait state, unmapped reads return zero
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ack_reg        <= 1'b0;
      avs_readdata_o <= 32'h0000_0000;
    end else begin
      ack_reg <= (avs_read_i || avs_write_i) && !ack_reg;
      if (rd_now) begin
        case (avs_address_i)
          OFF_T1_CTRL:  avs_readdata_o <= {16'h0000, ctrl_reg[0]};
          OFF_T1_CNT:   avs_readdata_o <= {16'h0000, cnt_reg[0]};
          OFF_T1_PER:   avs_readdata_o <= {16'h0000, per_reg[0]};
          OFF_CTRL_L_A: avs_readdata_o <= {16'h0000, ctrl_reg[1]};
          OFF_CTRL_U_A: avs_readdata_o <= {16'h0000, ctrl_reg[2]};
          OFF_CNT_L_A:  avs_readdata_o <= {16'h0000, cnt_reg[1]};
          OFF_CNT_U_A:  avs_readdata_o <= {16'h0000, cnt_reg[2]};
          OFF_PER_L_A:  avs_readdata_o <= {16'h0000, per_reg[1]};
          OFF_PER_U_A:  avs_readdata_o <= {16'h0000, per_reg[2]};
          OFF_CTRL_L_B: avs_readdata_o <= {16'h0000, ctrl_reg[3]};
          OFF_CTRL_U_B: avs_readdata_o <= {16'h0000, ctrl_reg[4]};
          OFF_CNT_L_B:  avs_readdata_o <= {16'h0000, cnt_reg[3]};
          OFF_CNT_U_B:  avs_readdata_o <= {16'h0000, cnt_reg[4]};
          OFF_PER_L_B:  avs_readdata_o <= {16'h0000, per_reg[3]};
          OFF_PER_U_B:  avs_readdata_o <= {16'h0000, per_reg[4]};
          OFF_FLAGS:    avs_readdata_o <= {27'h0000000, flag_reg};
          default:      avs_readdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !ack_reg;
endmodule
`default_nettype wire

//--- tb/gts_timer_set_monitor.sv
// Purpose: concurrent checks on the timer set ports
// Assumes: control writes land while write is high
// Notes:   shadows five control registers to know when timers stand still
`default_nettype none
module gts_monitor
  import gts_pkg::*;
(
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  input  wire logic [31:0] avs_readdata_o,
  input  wire logic        avs_waitrequest_o,
  // pins and events
  input  wire logic        idle_i,
  input  wire logic        standalone_ext_clock_pin_i,
  input  wire logic [3:0]  pair_ext_clock_pin_i,
  input  wire logic        standalone_gate_i,
  input  wire logic [3:0]  pair_gate_i,
  input  wire logic [4:0]  irq_flag_pulse_o,
  input  wire logic        adc_trigger_o
);
  logic [15:0] sh_reg [5];
  logic [1:0]  fz_reg [4];
  logic [3:0]  fz;
  logic        wr_ok;
  function automatic logic hold(input logic [15:0] c, input logic idl);
    return !c[BIT_RUN] || (c[BIT_HALT] && idl);
  endfunction
  assign wr_ok = avs_write_i && (avs_byteenable_i[1:0] == 2'b11);
  assign fz[0] = hold(sh_reg[0], idle_i);
  assign fz[1] = hold(sh_reg[1], idle_i) || sh_reg[1][BIT_JOIN];
  assign fz[2] = sh_reg[1][BIT_JOIN] ? hold(sh_reg[1], idle_i) : hold(sh_reg[2], idle_i);
  assign fz[3] = sh_reg[4][BIT_JOIN] ? hold(sh_reg[4], idle_i) : hold(sh_reg[3], idle_i);
  // shadow of written controls
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      sh_reg <= '{default: 16'h0};
    end else if (wr_ok) begin
      if (avs_address_i == OFF_T1_CTRL) sh_reg[0] <= avs_writedata_i[15:0];
      if (avs_address_i == OFF_CTRL_L_A) sh_reg[1] <= avs_writedata_i[15:0];
      if (avs_address_i == OFF_CTRL_U_A) sh_reg[2] <= avs_writedata_i[15:0];
      if (avs_address_i == OFF_CTRL_U_B) sh_reg[3] <= avs_writedata_i[15:0];
      if (avs_address_i == OFF_CTRL_L_B) sh_reg[4] <= avs_writedata_i[15:0];
    end
  end
  // cycles a timer has stood still, saturating
  always_ff @(posedge sys_clk_i) begin
    for (int i = 0; i < 4; i++) begin
      if (!rst_n_i || !fz[i]) fz_reg[i] <= 2'h0;
      else if (fz_reg[i] != 2'h3) fz_reg[i] <= fz_reg[i] + 2'h1;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_rd_acc;
    avs_read_i && avs_waitrequest_o ##1 avs_read_i && !avs_waitrequest_o;
  endsequence
  property p_rsv_zero;
    s_rd_acc |-> avs_readdata_o[31:16] == 16'h0 &&
      (avs_address_i != OFF_T1_CTRL || (avs_readdata_o[15:0] & ~MASK_T1) == 16'h0);
  endproperty
  property p_adc_src;
    adc_trigger_o == irq_flag_pulse_o[FLG_UA];
  endproperty
  property p_t1_hold;
    fz_reg[0] == 2'h3 |-> !irq_flag_pulse_o[FLG_T1];
  endproperty
  property p_la_hold;
    fz_reg[1] == 2'h3 |-> !irq_flag_pulse_o[FLG_LA];
  endproperty
  property p_ua_hold;
    fz_reg[2] == 2'h3 |-> !irq_flag_pulse_o[FLG_UA];
  endproperty
  property p_ub_hold;
    fz_reg[3] == 2'h3 |-> !irq_flag_pulse_o[FLG_UB];
  endproperty
  property p_reset_quiet;
    disable iff (1'b0) !rst_n_i |=> irq_flag_pulse_o == 5'h00 && !adc_trigger_o;
  endproperty
  property p_one_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=>
      !avs_waitrequest_o || !(avs_read_i || avs_write_i);
  endproperty
  a_rsv_zero: assert property (p_rsv_zero) else $error("reserved bits set");
  a_adc_src: assert property (p_adc_src) else $error("adc source wrong");
  a_t1_hold: assert property (p_t1_hold) else $error("stopped timer flagged");
  a_la_hold: assert property (p_la_hold) else $error("lower a flagged");
  a_ua_hold: assert property (p_ua_hold) else $error("upper a flagged");
  a_ub_hold: assert property (p_ub_hold) else $error("upper b flagged");
  a_reset_quiet: assert property (p_reset_quiet) else $error("event in reset");
  a_one_wait: assert property (p_one_wait) else $error("long wait state");
endmodule
bind gts_timer_set gts_monitor mon_u (
  .sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
  .idle_i, .standalone_ext_clock_pin_i, .pair_ext_clock_pin_i,
  .standalone_gate_i, .pair_gate_i, .irq_flag_pulse_o, .adc_trigger_o
);
`default_nettype wire

//--- tb/gts_testbench.sv
// Purpose: self-checking bench for the general timer set
// Assumes: one wait state per bus access
// Notes:   lower a pin clocks the joined pair; counts read back through the bus
`default_nettype none
module testbench
  import gts_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic        sys_clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [5:0]  avs_address_i = 6'h00;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0]  avs_byteenable_i = 4'hf;
  logic        idle_i = 1'b0;
  logic        standalone_ext_clock_pin_i = 1'b0;
  logic [3:0]  pair_ext_clock_pin_i = 4'h0;
  logic        standalone_gate_i = 1'b0;
  logic [3:0]  pair_gate_i = 4'h0;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o;
  logic [4:0]  irq_flag_pulse_o;
  logic        adc_trigger_o;
  logic [5:0]  ev;
  logic [31:0] q;
  logic [15:0] m;
  int          fail_count = 0;
  int          n_tests = 0;
  logic [5:0]  ctl [5] = '{OFF_T1_CTRL, OFF_CTRL_L_A, OFF_CTRL_U_A, OFF_CTRL_L_B, OFF_CTRL_U_B};
  logic [15:0] msk [5] = '{MASK_T1, MASK_LOWER, MASK_UPPER, MASK_LOWER, MASK_UPPER};
  int          ps_div [4] = '{1, 8, 64, 256};
  assign ev = {adc_trigger_o, irq_flag_pulse_o};
  always #12.5 sys_clk_i = ~sys_clk_i;
  gts_timer_set dut_u (
    .sys_clk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .idle_i, .standalone_ext_clock_pin_i, .pair_ext_clock_pin_i,
    .standalone_gate_i, .pair_gate_i, .irq_flag_pulse_o, .adc_trigger_o
  );
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic hang();
    fail_count++;
    $display("[FAIL] %0t wait limit", $time);
    final_report();
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic bus(input logic w, input logic [5:0] a, input logic [15:0] d);
    int   k;
    logic st;
    @(posedge sys_clk_i);
    avs_address_i   <= a;
    avs_writedata_i <= {16'h0, d};
    avs_write_i     <= w;
    avs_read_i      <= !w;
    k  = 0;
    st = 1'b1;
    do begin
      @(negedge sys_clk_i);
      st = avs_waitrequest_o;
      q  = avs_readdata_o;
      @(posedge sys_clk_i);
      k++;
    end while (st !== 1'b0 && k < 20);
    if (st !== 1'b0) hang();
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [5:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0);
    chk(q, {16'h0, e});
  endtask
  task automatic nxt(input int b, output int n);
    n = 0;
    do begin
      @(negedge sys_clk_i);
      n++;
    end while (ev[b] !== 1'b1 && n < 2000);
    if (n >= 2000) hang();
  endtask
  task automatic gap(input int b, output int n);
    nxt(b, n);
    nxt(b, n);
  endtask
  task automatic cnt(input int b, input int c, output int n);
    n = 0;
    repeat (c) begin
      @(negedge sys_clk_i);
      if (ev[b] === 1'b1) n++;
    end
  endtask
  initial begin
    int n;
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rdc(ctl[i], 16'h0000);
      wr(ctl[i], 16'hffff);
      rdc(ctl[i], msk[i]);
      wr(ctl[i], 16'h0000);
    end
    wr(OFF_FLAGS, 16'h001f);
    avs_byteenable_i <= 4'hc;
    wr(OFF_T1_CTRL, 16'h8000);
    avs_byteenable_i <= 4'hf;
    rdc(OFF_T1_CTRL, 16'h0000);
    $display("test registers done");
    wr(OFF_T1_PER, 16'h0001);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_T1_CTRL, 16'h0000);
      wr(OFF_T1_CTRL, {8'h80, 2'h0, i[1:0], 4'h0});
      gap(0, n);
      chk(n, 2 * ps_div[i]);
    end
    bus(1'b0, OFF_FLAGS, 16'h0);
    chk(q[0], 1'b1);
    wr(OFF_T1_CTRL, 16'h0000);
    wr(OFF_FLAGS, 16'h0001);
    rdc(OFF_FLAGS, 16'h0000);
    wr(OFF_T1_PER, 16'h0000);
    wr(OFF_T1_CTRL, 16'h8010);
    nxt(0, n);
    repeat (3) @(posedge sys_clk_i);
    wr(OFF_T1_CTRL, 16'h8010);
    nxt(0, n);
    chk(n >= 6, 1'b1);
    $display("test prescale done");
    wr(OFF_T1_CTRL, 16'h0000);
    wr(OFF_T1_PER, 16'h0001);
    idle_i <= 1'b1;
    wr(OFF_T1_CTRL, 16'ha000);
    cnt(0, 20, n);
    chk(n, 0);
    wr(OFF_T1_CTRL, 16'h8000);
    repeat (4) @(posedge sys_clk_i);
    cnt(0, 20, n);
    chk(n, 10);
    @(posedge sys_clk_i);
    idle_i <= 1'b0;
    wr(OFF_T1_CTRL, 16'h0000);
    $display("test idle done");
    wr(OFF_T1_PER, 16'hffff);
    wr(OFF_FLAGS, 16'h001f);
    bus(1'b0, OFF_T1_CNT, 16'h0);
    m = q[15:0] + 16'd20;
    wr(OFF_T1_CTRL, 16'h8040);
    standalone_gate_i <= 1'b1;
    repeat (20) @(posedge sys_clk_i);
    standalone_gate_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rdc(OFF_T1_CNT, m);
    bus(1'b0, OFF_FLAGS, 16'h0);
    chk(q[0], 1'b1);
    wr(OFF_FLAGS, 16'h0001);
    wr(OFF_T1_CTRL, 16'h8042);
    standalone_gate_i <= 1'b1;
    repeat (10) @(posedge sys_clk_i);
    standalone_gate_i <= 1'b0;
    repeat (8) @(posedge sys_clk_i);
    rdc(OFF_T1_CNT, m);
    rdc(OFF_FLAGS, 16'h0000);
    $display("test gate done");
    for (int s = 0; s < 2; s++) begin
      wr(OFF_T1_CTRL, {13'h1000, s[0], 2'h2});
      repeat (5) begin
        standalone_ext_clock_pin_i <= 1'b1;
        repeat (3) @(posedge sys_clk_i);
        standalone_ext_clock_pin_i <= 1'b0;
        repeat (3) @(posedge sys_clk_i);
      end
      repeat (6) @(posedge sys_clk_i);
      m = m + 16'd5;
      rdc(OFF_T1_CNT, m);
    end
    wr(OFF_T1_CTRL, 16'h0000);
    $display("test external clock done");
    wr(OFF_CTRL_L_A, 16'h0008);
    wr(OFF_CTRL_U_A, 16'h0030);
    wr(OFF_PER_L_A, 16'h0002);
    wr(OFF_PER_U_A, 16'h0000);
    wr(OFF_CTRL_L_A, 16'h8008);
    gap(2, n);
    chk(n, 3);
    cnt(1, 30, n);
    chk(n, 0);
    cnt(5, 30, n);
    chk(n, 10);
    wr(OFF_CTRL_L_A, 16'h0008);
    wr(OFF_PER_L_A, 16'hffff);
    wr(OFF_PER_U_A, 16'h0001);
    wr(OFF_CTRL_L_A, 16'h8008);
    cnt(2, 65546, n);
    chk(n, 0);
    wr(OFF_CTRL_L_A, 16'h0008);
    rdc(OFF_CNT_U_A, 16'h0001);
    bus(1'b0, OFF_CNT_L_A, 16'h0);
    m = q[15:0] + 16'd5;
    wr(OFF_CTRL_L_A, 16'h800a);
    repeat (5) begin
      pair_ext_clock_pin_i <= 4'h1;
      repeat (3) @(posedge sys_clk_i);
      pair_ext_clock_pin_i <= 4'h0;
      repeat (3) @(posedge sys_clk_i);
    end
    repeat (6) @(posedge sys_clk_i);
    rdc(OFF_CNT_L_A, m);
    wr(OFF_CTRL_L_A, 16'h0008);
    $display("test joined pair done");
    wr(OFF_PER_U_B, 16'h0001);
    wr(OFF_CTRL_U_B, 16'h8000);
    gap(4, n);
    chk(n, 2);
    cnt(5, 20, n);
    chk(n, 0);
    wr(OFF_CTRL_U_B, 16'h0000);
    wr(OFF_CTRL_L_A, 16'h0000);
    wr(OFF_PER_U_A, 16'h0001);
    wr(OFF_CTRL_U_A, 16'h8000);
    repeat (4) @(posedge sys_clk_i);
    cnt(5, 20, n);
    chk(n, 10);
    $display("test split pairs done");
    final_report();
  end
endmodule
`default_nettype wire
